// ===== core/cer_cfg.svh
// Constants for the configuration and arithmetic trap register bank.
// Assumes it is included by its bare name from the package and the module.
`ifndef CER_CFG_SVH
`define CER_CFG_SVH

// Special-register indices of the bank
`define CER_SPR_AW 16
`define CER_IDX_PERF_CAP 16'h0007
`define CER_IDX_IMPL_VER 16'h0009
`define CER_IDX_ARCH_VER 16'h000A
`define CER_IDX_VEC_BASE 16'h000B
`define CER_IDX_TRAP_CTL 16'h000C

// Field positions
`define CER_CNT_LSB 0
`define CER_CNT_W 3
`define CER_IMPL_ID_LSB 24
`define CER_IMPL_REV_LSB 0
`define CER_ARCH_MAJ_LSB 24
`define CER_ARCH_MIN_LSB 16
`define CER_ARCH_PATCH_LSB 8
`define CER_VBASE_LSB 13
`define CER_VBASE_W 19
`define CER_TRAP_W 7

// Trap enable bit positions
`define CER_TRAP_ADD_CY 0
`define CER_TRAP_ADD_OV 1
`define CER_TRAP_MUL_CY 2
`define CER_TRAP_MUL_OV 3
`define CER_TRAP_DIV_ZERO 4
`define CER_TRAP_MAC_CY 5
`define CER_TRAP_MAC_OV 6

// Reset values and the high vector page offset
`define CER_TRAP_RESET 7'h00
`define CER_WORD_ZERO 32'h0000_0000
`define CER_HIGH_PAGE_OFS 32'hF000_0000

`endif

// ===== core/cer_pkg.sv
// Types for the configuration and arithmetic trap register bank.
// Assumes cer_cfg.svh is on the include path.
`include "cer_cfg.svh"

package cer_pkg;

  // Complete registered state of the bank
  typedef struct packed {
    logic [31:0] rdata;
    logic ack;
    logic priv_err;
    logic [`CER_VBASE_W-1:0] vbase;
    logic [`CER_TRAP_W-1:0] trap_en;
    logic trap_exc;
    logic [`CER_TRAP_W-1:0] trap_cause;
    logic [31:0] vec_base;
    logic [31:0] vec_addr;
    logic impl_ver_present;
    logic arch_ver_present;
    logic vbase_present;
    logic trap_regs_present;
  } cer_state_s;

endpackage : cer_pkg

// ===== core/cer_regs.sv
// Supervisor special registers: counter capability, versions,
// exception vector base and arithmetic trap control.
// Assumes one core clock; all inputs come from logic on that clock.
//
// How it works
// (R01) Counter capability reads counter count minus one in bits 2-0.
// (R02) Capability register only reachable in supervisor mode, full 32-bit word.
// (R03) Implementation version: identifier bits 31-24, revision bits 23-0, read only.
// (R04) Revision is a parameter meant to increase with every new version.
// (R05) Identifier is a parameter meant unique to each implementation.
// (R06) Presence flag for implementation version fed to legacy version register.
// (R07) Architecture version: major 31-24, minor 23-16, patch 15-8, low byte zero.
// (R08) All presence flags of the reported version are driven set.
// (R09) Presence flag for architecture version fed to configuration register.
// (R10) Vector base writable in bits 31-13, low bits zero, reset parameter.
// (R11) Vector addresses offset by base, high page ORed when page bit set.
// (R12) Presence flag for vector base fed to configuration register.
// (R13) Trap control enables in bits 6-0 reset to zero, rest reserved.
// (R14) Enables act only while supervision trap enable is set; raise exception.
// (R15) Bit 0 traps add or subtract carry.
// (R16) Bit 1 traps add or subtract signed overflow.
// (R17) Bits 2 and 3 trap multiply carry and signed overflow.
// (R18) Bit 4 traps divide by zero from either divide form.
// (R19) Bits 5 and 6 trap carry and overflow in accumulate addition.
// (R20) Presence flag for trap control fed to configuration register.
// (R21) Writes to read-only or reserved bits ignored; reserved bits read zero.
`timescale 1ns/10ps
`include "cer_cfg.svh"

module cer_regs
  import cer_pkg::*;
#(
  parameter int NUM_PERF_COUNTERS = 8,
  parameter logic [7:0] IMPL_ID = 8'h5A,          // Arbitrary value
  parameter logic [23:0] IMPL_REV = 24'h00_0001,  // Arbitrary value
  parameter logic [7:0] ARCH_MAJOR = 8'h01,
  parameter logic [7:0] ARCH_MINOR = 8'h00,
  parameter logic [7:0] ARCH_PATCH = 8'h00,
  parameter logic [`CER_VBASE_W-1:0] VBASE_RESET = 19'h0_0000
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // Special-register move port
  input wire logic [`CER_SPR_AW-1:0] SPR_ADDR,
  input wire logic [31:0] SPR_WDATA,
  input wire logic SPR_WE,
  input wire logic SPR_RE,
  input wire logic SUPERVISOR_MODE,
  output logic [31:0] SPR_RDATA,
  output logic SPR_ACK,
  output logic SPR_PRIV_ERR,
  // Supervision register bits
  input wire logic ARITH_TRAP_ENABLE,
  input wire logic HIGH_VECTOR_PAGE_BIT,
  // Flag events from the arithmetic unit
  input wire logic ADD_CARRY_SET,
  input wire logic ADD_SIGNED_SET,
  input wire logic MUL_CARRY_SET,
  input wire logic MUL_SIGNED_SET,
  input wire logic DIV_ZERO_SET,
  input wire logic MAC_CARRY_SET,
  input wire logic MAC_SIGNED_SET,
  // Exception request
  output logic ARITH_EXCEPTION,
  output logic [`CER_TRAP_W-1:0] ARITH_TRAP_CAUSE,
  // Exception vectors
  input wire logic [12:0] EXC_VECTOR_OFFSET,
  output logic [31:0] EXC_VECTOR_BASE,
  output logic [31:0] EXC_VECTOR_ADDR,
  // Presence flags for the configuration registers
  output logic IMPL_VERSION_PRESENT,
  output logic ARCH_VERSION_PRESENT,
  output logic VECTOR_BASE_PRESENT,
  output logic ARITH_TRAP_REGS_PRESENT
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Index match for one register
  function automatic logic spr_hit(input logic [`CER_SPR_AW-1:0] addr, input logic [`CER_SPR_AW-1:0] idx);
    spr_hit = (addr == idx);
  endfunction

  // Vector base word from the stored field and page bit
  function automatic logic [31:0] base_word(input logic [`CER_VBASE_W-1:0] field, input logic high_page);
    logic [31:0] w;
    w = {field, 13'h0000};
    if (high_page) begin
      w = w | `CER_HIGH_PAGE_OFS;
    end
    base_word = w;
  endfunction

  localparam logic [`CER_CNT_W-1:0] COUNT_FIELD = `CER_CNT_W'(NUM_PERF_COUNTERS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Constant read words

  logic [31:0] perf_cap_word;
  logic [31:0] impl_ver_word;
  logic [31:0] arch_ver_word;
  logic [`CER_TRAP_W-1:0] flag_events;

  // Read-only words with reserved bits at zero
  always_comb begin
    perf_cap_word = `CER_WORD_ZERO;
    perf_cap_word[`CER_CNT_LSB +: `CER_CNT_W] = COUNT_FIELD; // see (R01)
    impl_ver_word = `CER_WORD_ZERO;
    impl_ver_word[`CER_IMPL_ID_LSB +: 8] = IMPL_ID; // see (R03) see (R05)
    impl_ver_word[`CER_IMPL_REV_LSB +: 24] = IMPL_REV; // see (R04)
    arch_ver_word = `CER_WORD_ZERO; // see (R21)
    arch_ver_word[`CER_ARCH_MAJ_LSB +: 8] = ARCH_MAJOR; // see (R07)
    arch_ver_word[`CER_ARCH_MIN_LSB +: 8] = ARCH_MINOR;
    arch_ver_word[`CER_ARCH_PATCH_LSB +: 8] = ARCH_PATCH;
  end

  // Flag events in trap control bit order
  always_comb begin
    flag_events = `CER_TRAP_RESET;
    flag_events[`CER_TRAP_ADD_CY] = ADD_CARRY_SET; // see (R15)
    flag_events[`CER_TRAP_ADD_OV] = ADD_SIGNED_SET; // see (R16)
    flag_events[`CER_TRAP_MUL_CY] = MUL_CARRY_SET; // see (R17)
    flag_events[`CER_TRAP_MUL_OV] = MUL_SIGNED_SET;
    flag_events[`CER_TRAP_DIV_ZERO] = DIV_ZERO_SET; // see (R18)
    flag_events[`CER_TRAP_MAC_CY] = MAC_CARRY_SET; // see (R19)
    flag_events[`CER_TRAP_MAC_OV] = MAC_SIGNED_SET;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  cer_state_s state;
  cer_state_s next_state;
  logic access;
  logic allowed;
  logic [`CER_TRAP_W-1:0] armed;

  // Next-state logic
  always_comb begin
    next_state = state;
    access = SPR_WE | SPR_RE;
    allowed = access & SUPERVISOR_MODE; // see (R02)
    next_state.ack = access;
    next_state.priv_err = access & ~SUPERVISOR_MODE;
    next_state.rdata = `CER_WORD_ZERO;

    // Register reads, unmapped or refused reads return zero
    if (allowed && SPR_RE) begin
      if (spr_hit(SPR_ADDR, `CER_IDX_PERF_CAP)) begin
        next_state.rdata = perf_cap_word; // see (R01) see (R02)
      end else if (spr_hit(SPR_ADDR, `CER_IDX_IMPL_VER)) begin
        next_state.rdata = impl_ver_word; // see (R03)
      end else if (spr_hit(SPR_ADDR, `CER_IDX_ARCH_VER)) begin
        next_state.rdata = arch_ver_word; // see (R07)
      end else if (spr_hit(SPR_ADDR, `CER_IDX_VEC_BASE)) begin
        next_state.rdata = {state.vbase, 13'h0000}; // see (R10) see (R21)
      end else if (spr_hit(SPR_ADDR, `CER_IDX_TRAP_CTL)) begin
        next_state.rdata = {25'h000_0000, state.trap_en}; // see (R13) see (R21)
      end
    end

    // Register writes, only the writable fields take data
    if (allowed && SPR_WE) begin
      if (spr_hit(SPR_ADDR, `CER_IDX_VEC_BASE)) begin
        next_state.vbase = SPR_WDATA[`CER_VBASE_LSB +: `CER_VBASE_W]; // see (R10) see (R21)
      end
      if (spr_hit(SPR_ADDR, `CER_IDX_TRAP_CTL)) begin
        next_state.trap_en = SPR_WDATA[`CER_TRAP_W-1:0]; // see (R13) see (R21)
      end
    end

    // Trap on enabled flag events, gated by the supervision enable
    armed = ARITH_TRAP_ENABLE ? (state.trap_en & flag_events) : `CER_TRAP_RESET; // see (R14)
    next_state.trap_exc = |armed; // see (R14)
    next_state.trap_cause = armed; // see (R15) see (R16) see (R17) see (R18) see (R19)

    // Vector base and addresses
    next_state.vec_base = base_word(state.vbase, HIGH_VECTOR_PAGE_BIT); // see (R11)
    next_state.vec_addr = base_word(state.vbase, HIGH_VECTOR_PAGE_BIT) | {19'h0_0000, EXC_VECTOR_OFFSET}; // see (R11)

    // Presence flags are set for this bank, cleared while reset is low
    next_state.impl_ver_present = 1'b1; // see (R06) see (R08)
    next_state.arch_ver_present = 1'b1; // see (R09) see (R08)
    next_state.vbase_present = 1'b1; // see (R12)
    next_state.trap_regs_present = 1'b1; // see (R20)

    // Synchronous reset
    if (!RST_B) begin
      next_state.rdata = `CER_WORD_ZERO;
      next_state.ack = 1'b0;
      next_state.priv_err = 1'b0;
      next_state.vbase = VBASE_RESET; // see (R10)
      next_state.trap_en = `CER_TRAP_RESET; // see (R13)
      next_state.trap_exc = 1'b0;
      next_state.trap_cause = `CER_TRAP_RESET;
      next_state.vec_base = `CER_WORD_ZERO;
      next_state.vec_addr = `CER_WORD_ZERO;
      next_state.impl_ver_present = 1'b0;
      next_state.arch_ver_present = 1'b0;
      next_state.vbase_present = 1'b0;
      next_state.trap_regs_present = 1'b0;
    end
  end

  // State register
  always_ff @(posedge SYS_CLK) begin
    state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register

  assign SPR_RDATA = state.rdata;
  assign SPR_ACK = state.ack;
  assign SPR_PRIV_ERR = state.priv_err;
  assign ARITH_EXCEPTION = state.trap_exc;
  assign ARITH_TRAP_CAUSE = state.trap_cause;
  assign EXC_VECTOR_BASE = state.vec_base;
  assign EXC_VECTOR_ADDR = state.vec_addr;
  assign IMPL_VERSION_PRESENT = state.impl_ver_present;
  assign ARCH_VERSION_PRESENT = state.arch_ver_present;
  assign VECTOR_BASE_PRESENT = state.vbase_present;
  assign ARITH_TRAP_REGS_PRESENT = state.trap_regs_present;

endmodule // cer_regs

// ===== dv/cer_regs_assertions.sv
// Assertions on the register bank ports.
// Assumes binding to cer_regs, one clock, synchronous active-low reset.
`timescale 1ns/10ps
`include "cer_cfg.svh"
module cer_regs_chk
  import cer_pkg::*;
#(parameter int NUM_PERF_COUNTERS = 8) (
  // Watched ports
  input wire logic SYS_CLK, RST_B, SPR_WE, SPR_RE, SUPERVISOR_MODE, SPR_ACK, SPR_PRIV_ERR,
  input wire logic [`CER_SPR_AW-1:0] SPR_ADDR,
  input wire logic [31:0] SPR_RDATA, EXC_VECTOR_BASE,
  input wire logic HIGH_VECTOR_PAGE_BIT, ARITH_TRAP_ENABLE, ARITH_EXCEPTION,
  input wire logic [`CER_TRAP_W-1:0] ARITH_TRAP_CAUSE,
  input wire logic IMPL_VERSION_PRESENT, ARCH_VERSION_PRESENT, VECTOR_BASE_PRESENT, ARITH_TRAP_REGS_PRESENT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  logic req;
  assign req = SPR_WE | SPR_RE;
  ////////////////////////////////////////////////////////////////////////////////
  // Request answered after one cycle
  sequence s_req_ack;
    req ##1 SPR_ACK;
  endsequence
  a_ack_after_req: assert property (req |-> s_req_ack)
    else $error("ack missing after request");
  a_ack_spurious: assert property (!req |=> !SPR_ACK)
    else $error("ack without request");
  a_priv_refuse: assert property (req && !SUPERVISOR_MODE |=> SPR_PRIV_ERR && SPR_RDATA == 32'h0)
    else $error("user access not refused");
  a_perf_value: assert property (SPR_RE && SUPERVISOR_MODE && SPR_ADDR == `CER_IDX_PERF_CAP
    |=> SPR_RDATA == 32'(NUM_PERF_COUNTERS - 1))
    else $error("counter capability wrong");
  a_arch_low_byte: assert property (SPR_RE && SPR_ADDR == `CER_IDX_ARCH_VER |=> SPR_RDATA[7:0] == 8'h00)
    else $error("arch version low byte set");
  a_base_low_zero: assert property (EXC_VECTOR_BASE[12:0] == 13'h0000)
    else $error("vector base low bits set");
  a_high_page: assert property (HIGH_VECTOR_PAGE_BIT |=> EXC_VECTOR_BASE[31:28] == 4'hF)
    else $error("high page not ORed");
  a_trap_gated: assert property (!ARITH_TRAP_ENABLE |=> !ARITH_EXCEPTION && ARITH_TRAP_CAUSE == 7'h00)
    else $error("trap while disabled");
  a_cause_flag: assert property (ARITH_EXCEPTION == (ARITH_TRAP_CAUSE != 7'h00))
    else $error("cause and exception disagree");
  a_present_set: assert property (RST_B |=> IMPL_VERSION_PRESENT && ARCH_VERSION_PRESENT
    && VECTOR_BASE_PRESENT && ARITH_TRAP_REGS_PRESENT)
    else $error("presence flag clear");
endmodule // cer_regs_chk

bind cer_regs cer_regs_chk #(.NUM_PERF_COUNTERS(NUM_PERF_COUNTERS)) u_cer_regs_chk (.SYS_CLK, .RST_B, .SPR_WE,
  .SPR_RE, .SUPERVISOR_MODE, .SPR_ACK, .SPR_PRIV_ERR, .SPR_ADDR, .SPR_RDATA, .EXC_VECTOR_BASE,
  .HIGH_VECTOR_PAGE_BIT, .ARITH_TRAP_ENABLE, .ARITH_EXCEPTION, .ARITH_TRAP_CAUSE, .IMPL_VERSION_PRESENT,
  .ARCH_VERSION_PRESENT, .VECTOR_BASE_PRESENT, .ARITH_TRAP_REGS_PRESENT);

// ===== dv/cer_regs_tb.sv
// Self-checking bench for the register bank.
// Assumes cer_regs and its checker are compiled first.
`timescale 1ns/10ps
`include "cer_cfg.svh"
module cer_regs_tb import cer_pkg::*;;
  localparam logic [7:0] ID = 8'h3C; // Arbitrary value
  localparam logic [23:0] ARCH_PATCH_LEVEL = 24'h00_0102;
  localparam logic [18:0] VB = 19'h1_2345;
  logic SYS_CLK = 0, RST_B = 0, we = 0, re = 0, sup = 1, ate = 0, hpage = 0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0, rdata, vbase, vaddr;
  logic [12:0] ofs = 13'h0123;
  logic [6:0] ev = 7'h00, cause;
  logic ack, perr, exc, p0, p1, p2, p3;
  int failures = 0, num_checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Device under test
  cer_regs #(.IMPL_ID(ID), .IMPL_REV(ARCH_PATCH_LEVEL), .ARCH_MAJOR(8'h01), .ARCH_MINOR(8'h04), .ARCH_PATCH(8'h02),
    .VBASE_RESET(VB)) u_cer_regs (.SYS_CLK, .RST_B, .SPR_ADDR(addr), .SPR_WDATA(wdata), .SPR_WE(we),
    .SPR_RE(re), .SUPERVISOR_MODE(sup), .SPR_RDATA(rdata), .SPR_ACK(ack), .SPR_PRIV_ERR(perr),
    .ARITH_TRAP_ENABLE(ate), .HIGH_VECTOR_PAGE_BIT(hpage), .ADD_CARRY_SET(ev[0]), .ADD_SIGNED_SET(ev[1]),
    .MUL_CARRY_SET(ev[2]), .MUL_SIGNED_SET(ev[3]), .DIV_ZERO_SET(ev[4]), .MAC_CARRY_SET(ev[5]),
    .MAC_SIGNED_SET(ev[6]), .ARITH_EXCEPTION(exc), .ARITH_TRAP_CAUSE(cause), .EXC_VECTOR_OFFSET(ofs),
    .EXC_VECTOR_BASE(vbase), .EXC_VECTOR_ADDR(vaddr), .IMPL_VERSION_PRESENT(p0), .ARCH_VERSION_PRESENT(p1),
    .VECTOR_BASE_PRESENT(p2), .ARITH_TRAP_REGS_PRESENT(p3));
  // 40 MHz clock
  initial forever #12.5 SYS_CLK = ~SYS_CLK;
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One access, answer checked a cycle later
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic s,
                     input logic [31:0] exp);
    @(posedge SYS_CLK);
    #1;
    we = w;
    re = !w;
    addr = a;
    wdata = d;
    sup = s;
    @(posedge SYS_CLK);
    #1;
    we = 0;
    re = 0;
    chk(rdata, exp);
    chk(32'({ack, perr}), 32'({1'b1, !s}));
  endtask
  // One event cycle, exception checked a cycle later
  task automatic trap(input logic [6:0] e, input logic [6:0] exp);
    @(posedge SYS_CLK);
    #1;
    ev = e;
    @(posedge SYS_CLK);
    #1;
    ev = 7'h00;
    chk(32'({exc, cause}), 32'({exp != 7'h00, exp}));
  endtask
  // Verdict and end of run
  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge SYS_CLK);
    #1;
    RST_B = 1;
    acc(0, `CER_IDX_PERF_CAP, 32'h0, 1, 32'h0000_0007);
    chk(32'({p0, p1, p2, p3}), 32'h0000_000F);
    acc(0, `CER_IDX_IMPL_VER, 32'h0, 1, {ID, ARCH_PATCH_LEVEL});
    acc(0, `CER_IDX_ARCH_VER, 32'h0, 1, 32'h0104_0200);
    acc(0, `CER_IDX_VEC_BASE, 32'h0, 1, {VB, 13'h0000});
    acc(0, `CER_IDX_TRAP_CTL, 32'h0, 1, 32'h0);
    acc(1, `CER_IDX_PERF_CAP, 32'hFFFF_FFFF, 1, 32'h0);
    acc(0, `CER_IDX_PERF_CAP, 32'h0, 1, 32'h0000_0007);
    acc(0, 16'h0123, 32'h0, 1, 32'h0);
    acc(1, `CER_IDX_VEC_BASE, 32'h0000_5FFF, 1, 32'h0);
    acc(0, `CER_IDX_VEC_BASE, 32'h0, 1, 32'h0000_4000);
    chk(vbase, 32'h0000_4000);
    hpage = 1;
    repeat (2) @(posedge SYS_CLK);
    #1;
    chk(vbase, 32'hF000_4000);
    chk(vaddr, 32'hF000_4123);
    acc(1, `CER_IDX_TRAP_CTL, 32'hFFFF_FFFF, 1, 32'h0);
    acc(0, `CER_IDX_TRAP_CTL, 32'h0, 1, 32'h0000_007F);
    acc(1, `CER_IDX_TRAP_CTL, 32'h0, 0, 32'h0);
    acc(0, `CER_IDX_TRAP_CTL, 32'h0, 0, 32'h0);
    acc(0, `CER_IDX_TRAP_CTL, 32'h0, 1, 32'h0000_007F);
    ate = 1;
    for (int i = 0; i < 7; i++) begin
      acc(1, `CER_IDX_TRAP_CTL, 32'(1 << i), 1, 32'h0);
      trap(7'h7F, 7'(1 << i));
      trap(7'(~(1 << i)), 7'h00);
    end
    ate = 0;
    trap(7'h7F, 7'h00);
    RST_B = 0;
    repeat (2) @(posedge SYS_CLK);
    #1;
    chk(32'({p0, p1, p2, p3}), 32'h0000_0000);
    chk(vbase, 32'h0000_0000);
    RST_B = 1;
    acc(0, `CER_IDX_TRAP_CTL, 32'h0, 1, 32'h0);
    acc(0, `CER_IDX_VEC_BASE, 32'h0, 1, {VB, 13'h0000});
    chk(32'({p0, p1, p2, p3}), 32'h0000_000F);
    conclude();
  end
  // Hang guard
  initial begin
    #1_000_000;
    failures++;
    conclude();
  end
endmodule // cer_regs_tb
